// ---- design/amb_pkg.sv ----
// Purpose: Shared constants and types of the alert mask bank link.
// Assumes: One clock for both ends; bytes are 8 bits.
// Notes: Category i of the packed buses sits in byte i.
`default_nettype none
package amb_pkg;
   // Link command codes
   localparam logic [7:0] AMB_MASK_CMD = 8'h1b;
   localparam logic [7:0] AMB_SEL_IOUT = 8'h7b;
   localparam logic [7:0] AMB_SEL_INPUT = 8'h7c;
   localparam logic [7:0] AMB_SEL_TEMP = 8'h7d;
   localparam logic [7:0] AMB_SEL_CML = 8'h7e;
   localparam logic [7:0] AMB_SEL_OTHER = 8'h7f;
   localparam logic [7:0] AMB_PHASE_ALL = 8'hff;
   localparam logic [7:0] AMB_BLOCK_COUNT = 8'h01;
   localparam int AMB_CATEGORIES = 4;
   // Field positions inside the mask bytes
   localparam int AMB_OVERCURRENT_FAULT_MASK_BIT = 7;
   localparam int AMB_OVERCURRENT_WARNING_MASK_BIT = 5;
   localparam int AMB_UNDERCURRENT_FAULT_MASK_BIT = 4;
   localparam int AMB_INPUT_OVERVOLTAGE_FAULT_MASK_BIT = 7;
   localparam int AMB_INPUT_OVERVOLTAGE_WARNING_MASK_BIT = 6;
   localparam int AMB_INPUT_UNDERVOLTAGE_WARNING_MASK_BIT = 5;
   localparam int AMB_LOW_INPUT_MASK_BIT = 3;
   localparam int AMB_OVERTEMP_FAULT_MASK_BIT = 7;
   localparam int AMB_OVERTEMP_WARNING_MASK_BIT = 6;
   localparam int AMB_INVALID_COMMAND_MASK_BIT = 7;
   localparam int AMB_INVALID_DATA_MASK_BIT = 6;
   localparam int AMB_PACKET_CHECK_ERROR_MASK_BIT = 5;
   localparam int AMB_MEMORY_FAULT_MASK_BIT = 4;
   localparam int AMB_PROCESSOR_FAULT_MASK_BIT = 3;
   localparam int AMB_OTHER_COMM_FAULT_MASK_BIT = 1;
   // Writable bits per category
   localparam logic [7:0] AMB_IOUT_WR = 8'((1 << AMB_OVERCURRENT_FAULT_MASK_BIT)
      | (1 << AMB_OVERCURRENT_WARNING_MASK_BIT)
      | (1 << AMB_UNDERCURRENT_FAULT_MASK_BIT));
   localparam logic [7:0] AMB_INPUT_VOL = 8'(
      (1 << AMB_INPUT_OVERVOLTAGE_FAULT_MASK_BIT)
      | (1 << AMB_INPUT_OVERVOLTAGE_WARNING_MASK_BIT)
      | (1 << AMB_INPUT_UNDERVOLTAGE_WARNING_MASK_BIT));
   localparam logic [7:0] AMB_INPUT_NV = 8'(1 << AMB_LOW_INPUT_MASK_BIT);
   localparam logic [7:0] AMB_TEMP_WR = 8'((1 << AMB_OVERTEMP_FAULT_MASK_BIT)
      | (1 << AMB_OVERTEMP_WARNING_MASK_BIT));
   localparam logic [7:0] AMB_CML_WR = 8'((1 << AMB_INVALID_COMMAND_MASK_BIT)
      | (1 << AMB_INVALID_DATA_MASK_BIT)
      | (1 << AMB_PACKET_CHECK_ERROR_MASK_BIT)
      | (1 << AMB_MEMORY_FAULT_MASK_BIT)
      | (1 << AMB_PROCESSOR_FAULT_MASK_BIT)
      | (1 << AMB_OTHER_COMM_FAULT_MASK_BIT));
   localparam logic [31:0] AMB_WRITABLE = {AMB_CML_WR, AMB_TEMP_WR,
      AMB_INPUT_VOL | AMB_INPUT_NV, AMB_IOUT_WR};
   localparam logic [31:0] AMB_NVM_BACKED = {AMB_CML_WR, AMB_TEMP_WR,
      AMB_INPUT_NV, AMB_IOUT_WR};
   localparam logic [7:0] AMB_MASK_RESET = 8'h00;
   localparam logic [7:0] AMB_OTHER_MASK = 8'h01;
   // Host register map and fields
   localparam logic [7:0] AMB_REG_CMD = 8'h00;
   localparam logic [7:0] AMB_REG_RESULT = 8'h04;
   localparam logic [7:0] AMB_REG_INT_STATUS = 8'h08;
   localparam logic [7:0] AMB_REG_INT_CLEAR = 8'h0c;
   localparam logic [7:0] AMB_REG_INT_ENABLE = 8'h10;
   localparam int AMB_CMD_SEL_LSB = 0;
   localparam int AMB_CMD_MASK_LSB = 8;
   localparam int AMB_CMD_PHASE_LSB = 16;
   localparam int AMB_CMD_READ_BIT = 24;
   localparam int AMB_RES_BUSY_BIT = 0;
   localparam int AMB_RES_ERROR_BIT = 1;
   localparam int AMB_RES_DATA_LSB = 8;
   localparam int AMB_INT_WIDTH = 3;
   localparam int AMB_INT_DONE_BIT = 0;
   localparam int AMB_INT_ERROR_BIT = 1;
   localparam int AMB_INT_ALERT_BIT = 2;
   localparam logic [2:0] AMB_INT_RESET = 3'h0;
   typedef enum logic [1:0] {AMB_IDLE, AMB_SEND, AMB_WAIT}
      amb_host_state_type;
endpackage
`default_nettype wire

// ---- design/amb_link_if.sv ----
// Purpose: Transaction link between mask host and mask device.
// Assumes: Both ends run on the same CLK.
// Notes: Alert line is open drain; pulled high unless the device sinks it.
`default_nettype none
interface amb_link_if;
   logic req_valid;
   logic req_write;
   logic [7:0] req_cmd;
   logic [7:0] req_phase;
   logic [7:0] req_count;
   logic [7:0] req_lo;
   logic [7:0] req_hi;
   logic rsp_valid;
   logic rsp_error;
   logic [7:0] rsp_count;
   logic [7:0] rsp_data;
   logic alert_o;
   logic alert_oe_n;
   logic alert_n;
   // Wired level of the alert line
   assign alert_n = alert_oe_n ? 1'b1 : alert_o;
   modport dev (input req_valid, req_write, req_cmd, req_phase, req_count,
      req_lo, req_hi, alert_n, output rsp_valid, rsp_error, rsp_count,
      rsp_data, alert_o, alert_oe_n);
   modport host (output req_valid, req_write, req_cmd, req_phase, req_count,
      req_lo, req_hi, input rsp_valid, rsp_error, rsp_count, rsp_data,
      alert_n);
endinterface
`default_nettype wire

// ---- design/amb_mask_byte.sv ----
// Purpose: One mask byte with writable and stored-copy bit selects.
// Assumes: load pulses once after reset release.
// Notes: Bits outside WRITABLE stay zero whatever is written.
`default_nettype none
module amb_mask_byte #(
   parameter logic [7:0] WRITABLE = 8'hff,
   parameter logic [7:0] NVM_BACKED = 8'hff
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic load,
   input wire logic [7:0] nvm,
   input wire logic wr,
   input wire logic [7:0] wdata,
   output logic [7:0] q
);
   logic [7:0] q_reg;
   logic [7:0] q_next;
   // Write beats the power-up load; unsupported bits drop
   assign q_next = wr ? (wdata & WRITABLE) :
      (load ? (nvm & NVM_BACKED) : q_reg);
   assign q = q_reg;
   // Update on the fly, conversion never paused
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         q_reg <= amb_pkg::AMB_MASK_RESET;
      else
         q_reg <= q_next;
   end
endmodule
`default_nettype wire

// ---- design/amb_device.sv ----
// Purpose: Alert mask bank of the power converter, link slave end.
// Assumes: STATUS comes already latched from the status logic.
// Notes: Byte i of STATUS, NVM_MASKS and MASKS is category i.
// Contract
// - Mask 0 passes alert, 1 blocks it
// - Current mask writable at bits 7,5,4
// - Selector 7Ch picks input mask
// - Selector 7Dh picks temperature mask
// - Selector 7Eh picks communication/logic mask
// - Selector 7Fh picks fixed other mask
// - Access only with phase FFh
// - Unsupported bits read zero, ignore writes
// - Write word: low selector, high mask
// - Read: one-byte block in, one out
// - Masking never alters status bits
`default_nettype none
module amb_device (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic [31:0] STATUS,
   input wire logic [31:0] NVM_MASKS,
   output logic [31:0] MASKS,
   output logic ALERT,
   amb_link_if.dev LINK
);
   localparam int N = amb_pkg::AMB_CATEGORIES;
   logic loaded_reg;
   logic alert_reg;
   logic alert_next;
   logic rsp_valid_reg;
   logic rsp_error_reg;
   logic [7:0] rsp_data_reg;
   logic [7:0] rsp_count_reg;
   logic [7:0] rsp_data_next;
   logic [N-1:0] cat_hit;
   logic [N-1:0] cat_wr;
   logic [8*N-1:0] rd_term;
   logic [8*N-1:0] q_all;
   logic other_hit;
   logic frame_ok;
   logic accept;
   logic [7:0] rd_data;

   // Frame checks: command code, phase, block length on reads only
   assign frame_ok = (LINK.req_cmd == amb_pkg::AMB_MASK_CMD)
      && (LINK.req_phase == amb_pkg::AMB_PHASE_ALL)
      && (LINK.req_write
      || LINK.req_count == amb_pkg::AMB_BLOCK_COUNT);
   assign other_hit = LINK.req_lo == amb_pkg::AMB_SEL_OTHER;
   assign accept = LINK.req_valid && frame_ok && ((|cat_hit) || other_hit);

   // One mask byte per category; selectors are consecutive codes
   genvar i;
   generate
      for (i = 0; i < N; i++)
      begin : g_cat
         assign cat_hit[i] = LINK.req_lo
            == 8'(amb_pkg::AMB_SEL_IOUT + i);
         assign cat_wr[i] = accept && LINK.req_write
            && cat_hit[i];
         assign rd_term[8*i +: 8] = cat_hit[i] ? q_all[8*i +: 8] : 8'h00;
         amb_mask_byte #(
            .WRITABLE(amb_pkg::AMB_WRITABLE[8*i +: 8]),
            .NVM_BACKED(amb_pkg::AMB_NVM_BACKED[8*i +: 8])
         ) u_mask (
            .clk(CLK),
            .rstn(RSTN),
            .load(!loaded_reg),
            .nvm(NVM_MASKS[8*i +: 8]),
            .wr(cat_wr[i]),
            .wdata(LINK.req_hi),
            .q(q_all[8*i +: 8])
         );
      end
   endgenerate

   // Read path; other mask is constant, so writes to it change nothing
   assign rd_data = rd_term[7:0] | rd_term[15:8] | rd_term[23:16]
      | rd_term[31:24]
      | (other_hit ? amb_pkg::AMB_OTHER_MASK : 8'h00);
   assign rsp_data_next = (accept && !LINK.req_write) ? rd_data : 8'h00;

   // Status passes untouched; only its route to the alert is gated
   assign alert_next = |(STATUS & ~q_all);

   assign MASKS = q_all;
   assign ALERT = alert_reg;
   assign LINK.alert_o = 1'b0;
   assign LINK.alert_oe_n = !alert_reg;
   assign LINK.rsp_valid = rsp_valid_reg;
   assign LINK.rsp_error = rsp_error_reg;
   assign LINK.rsp_data = rsp_data_reg;
   assign LINK.rsp_count = rsp_count_reg;

   // Power-up load flag; stored copy taken on first edge after release
   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
         loaded_reg <= 1'b0;
      else
         loaded_reg <= 1'b1;
   end

   // Alert level, registered to keep the pin glitch free
   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
         alert_reg <= 1'b0;
      else
         alert_reg <= alert_next;
   end

   // Answer one cycle after each request
   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         rsp_valid_reg <= 1'b0;
         rsp_error_reg <= 1'b0;
         rsp_data_reg <= 8'h00;
         rsp_count_reg <= 8'h00;
      end
      else
      begin
         rsp_valid_reg <= LINK.req_valid;
         rsp_error_reg <= LINK.req_valid && !accept;
         rsp_data_reg <= rsp_data_next;
         rsp_count_reg <= (accept && !LINK.req_write) ?
            amb_pkg::AMB_BLOCK_COUNT : 8'h00;
      end
   end
endmodule
`default_nettype wire

// ---- design/amb_host.sv ----
// Purpose: Host end: APB registers drive mask writes and reads.
// Assumes: One request in flight; device always ready.
// Notes: PREADY is tied high, answers come with no wait state.
`default_nettype none
module amb_host (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   output logic IRQ,
   amb_link_if.host LINK
);
   amb_pkg::amb_host_state_type state_reg;
   amb_pkg::amb_host_state_type state_next;
   logic [7:0] sel_reg;
   logic [7:0] mask_reg;
   logic [7:0] phase_reg;
   logic read_reg;
   logic err_reg;
   logic [7:0] data_reg;
   logic [2:0] int_status_reg;
   logic [2:0] int_status_next;
   logic [2:0] int_enable_reg;
   logic [2:0] int_events;
   logic [2:0] clr_bits;
   logic [31:0] prdata_reg;
   logic [31:0] rd_mux;
   logic wr_en;
   logic rd_setup;
   logic cmd_wr;
   logic clr_wr;
   logic en_wr;
   logic done_ev;
   logic busy;

   // APB decode; no wait states, so access edge is the commit edge
   assign wr_en = PSEL && PENABLE && PWRITE;
   assign rd_setup = PSEL && !PENABLE;
   assign cmd_wr = wr_en && (PADDR == amb_pkg::AMB_REG_CMD)
      && (state_reg == amb_pkg::AMB_IDLE);
   assign clr_wr = wr_en && (PADDR == amb_pkg::AMB_REG_INT_CLEAR);
   assign en_wr = wr_en && (PADDR == amb_pkg::AMB_REG_INT_ENABLE);
   assign busy = state_reg != amb_pkg::AMB_IDLE;
   assign done_ev = (state_reg == amb_pkg::AMB_WAIT) && LINK.rsp_valid;

   // Sticky events; a clear in the same cycle loses to a new event
   assign int_events = {!LINK.alert_n, done_ev && LINK.rsp_error, done_ev};
   assign clr_bits = clr_wr ? PWDATA[2:0] : 3'h0;
   assign int_status_next = (int_status_reg & ~clr_bits) | int_events;

   // Read mux, latched in the setup cycle so data stands at access
   assign rd_mux = (PADDR == amb_pkg::AMB_REG_RESULT) ?
      {16'h0000, data_reg, 6'h00, err_reg, busy} :
      (PADDR == amb_pkg::AMB_REG_INT_STATUS) ? {29'h0, int_status_reg} :
      (PADDR == amb_pkg::AMB_REG_INT_ENABLE) ? {29'h0, int_enable_reg} :
      (PADDR == amb_pkg::AMB_REG_CMD) ?
      {7'h00, read_reg, phase_reg, mask_reg, sel_reg} : 32'h0;

   assign PRDATA = prdata_reg;
   assign PREADY = 1'b1;
   assign PSLVERR = 1'b0;
   assign IRQ = |(int_status_reg & int_enable_reg);

   // Request held from send until the answer is seen
   assign LINK.req_valid = busy;
   assign LINK.req_write = !read_reg;
   assign LINK.req_cmd = amb_pkg::AMB_MASK_CMD;
   assign LINK.req_phase = phase_reg;
   assign LINK.req_count = amb_pkg::AMB_BLOCK_COUNT;
   assign LINK.req_lo = sel_reg;
   assign LINK.req_hi = mask_reg;

   // Transfer sequencer
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         amb_pkg::AMB_IDLE:
            if (cmd_wr)
               state_next = amb_pkg::AMB_SEND;
         amb_pkg::AMB_SEND:
            state_next = amb_pkg::AMB_WAIT;
         amb_pkg::AMB_WAIT:
            if (LINK.rsp_valid)
               state_next = amb_pkg::AMB_IDLE;
         default:
            state_next = amb_pkg::AMB_IDLE;
      endcase
   end

   // State and command fields
   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         state_reg <= amb_pkg::AMB_IDLE;
         sel_reg <= 8'h00;
         mask_reg <= 8'h00;
         phase_reg <= 8'h00;
         read_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         if (cmd_wr)
         begin
            sel_reg <= PWDATA[amb_pkg::AMB_CMD_SEL_LSB +: 8];
            mask_reg <= PWDATA[amb_pkg::AMB_CMD_MASK_LSB +: 8];
            phase_reg <= PWDATA[amb_pkg::AMB_CMD_PHASE_LSB +: 8];
            read_reg <= PWDATA[amb_pkg::AMB_CMD_READ_BIT];
         end
      end
   end

   // Answer capture and read data
   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         err_reg <= 1'b0;
         data_reg <= 8'h00;
         prdata_reg <= 32'h0;
      end
      else
      begin
         if (done_ev)
         begin
            err_reg <= LINK.rsp_error;
            data_reg <= LINK.rsp_data;
         end
         if (rd_setup)
            prdata_reg <= rd_mux;
      end
   end

   // Interrupt registers
   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         int_status_reg <= amb_pkg::AMB_INT_RESET;
         int_enable_reg <= amb_pkg::AMB_INT_RESET;
      end
      else
      begin
         int_status_reg <= int_status_next;
         if (en_wr)
            int_enable_reg <= PWDATA[2:0];
      end
   end
endmodule
`default_nettype wire

// ---- sim/amb_link_props.sv ----
// Purpose: Link checker for the alert mask bank.
// Assumes: A request stays up until its answer.
// Notes: Eight cycle answer bound is our choice.
`default_nettype none
module amb_link_props (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic [7:0] req_cmd,
   input wire logic [7:0] req_phase,
   input wire logic [7:0] req_count,
   input wire logic [7:0] req_lo,
   input wire logic rsp_valid,
   input wire logic rsp_error,
   input wire logic [7:0] rsp_count,
   input wire logic [7:0] rsp_data,
   input wire logic alert_o,
   input wire logic alert_oe_n
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RSTN);
   // Answered read that came back without error
   wire rd = rsp_valid && req_valid && !req_write && !rsp_error;
   property p_cmd; req_valid |-> req_cmd == amb_pkg::AMB_MASK_CMD; endproperty
   a_cmd: assert property (p_cmd) else $error("bad code");
   property p_cnt;
      req_valid && !req_write |-> req_count == amb_pkg::AMB_BLOCK_COUNT;
   endproperty
   a_cnt: assert property (p_cnt) else $error("bad count");
   property p_ans; $rose(req_valid) |-> ##[0:8] rsp_valid; endproperty
   a_ans: assert property (p_ans) else $error("no answer");
   property p_ph;
      req_valid && req_phase != amb_pkg::AMB_PHASE_ALL
         |-> ##[0:8] rsp_valid && rsp_error;
   endproperty
   a_ph: assert property (p_ph) else $error("phase taken");
   property p_rc; rd |-> rsp_count == amb_pkg::AMB_BLOCK_COUNT; endproperty
   a_rc: assert property (p_rc) else $error("bad rsp count");
   property p_tmp;
      rd && req_lo == amb_pkg::AMB_SEL_TEMP |-> rsp_data[5:0] == 6'h00;
   endproperty
   a_tmp: assert property (p_tmp) else $error("temp bits");
   property p_io;
      rd && req_lo == amb_pkg::AMB_SEL_IOUT
         |-> (rsp_data & ~amb_pkg::AMB_IOUT_WR) == 8'h00;
   endproperty
   a_io: assert property (p_io) else $error("current bits");
   property p_oth;
      rd && req_lo == amb_pkg::AMB_SEL_OTHER
         |-> rsp_data == amb_pkg::AMB_OTHER_MASK;
   endproperty
   a_oth: assert property (p_oth) else $error("other mask");
   property p_od; !alert_oe_n |-> !alert_o; endproperty
   a_od: assert property (p_od) else $error("alert drives high");
   c_rd: cover property (rd);
   c_err: cover property (rsp_valid && rsp_error);
   c_alert: cover property (!alert_oe_n);
endmodule
`default_nettype wire

// ---- sim/alert_mask_bank_tb_top.sv ----
// Purpose: Bench joining host and device ends of the mask bank.
// Assumes: A command register write starts one link transfer.
// Notes: Masks come from a 16-bit LFSR; first pass writes all ones.
`default_nettype none
module alert_mask_bank_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic CLK = 1'b0;
   logic RSTN = 1'b0;
   logic PSEL = 1'b0;
   logic PENABLE = 1'b0;
   logic PWRITE = 1'b0;
   logic [7:0] PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0;
   logic [31:0] STATUS = 32'h0;
   logic [31:0] NVM_MASKS = 32'hffffffff;
   logic [31:0] PRDATA, MASKS, r, exp_m;
   logic PREADY, PSLVERR, IRQ, ALERT;
   logic [15:0] seed = 16'h80b6;
   logic [7:0] m;
   int num_errors = 0;
   int n_checks = 0;
   int cycles = 0;
   int c;
   amb_link_if u_amb_link_if ();
   amb_host u_amb_host (.CLK(CLK), .RSTN(RSTN), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
      .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ),
      .LINK(u_amb_link_if));
   amb_device u_amb_device (.CLK(CLK), .RSTN(RSTN), .STATUS(STATUS),
      .NVM_MASKS(NVM_MASKS), .MASKS(MASKS), .ALERT(ALERT),
      .LINK(u_amb_link_if));
   amb_link_props u_amb_link_props (.CLK(CLK), .RSTN(RSTN),
      .req_valid(u_amb_link_if.req_valid), .req_write(u_amb_link_if.req_write),
      .req_cmd(u_amb_link_if.req_cmd), .req_phase(u_amb_link_if.req_phase),
      .req_count(u_amb_link_if.req_count), .req_lo(u_amb_link_if.req_lo),
      .rsp_valid(u_amb_link_if.rsp_valid), .rsp_error(u_amb_link_if.rsp_error),
      .rsp_count(u_amb_link_if.rsp_count), .rsp_data(u_amb_link_if.rsp_data),
      .alert_o(u_amb_link_if.alert_o), .alert_oe_n(u_amb_link_if.alert_oe_n));
   always #4 CLK = ~CLK;
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      n_checks++;
      if (seen !== want)
      begin
         num_errors++;
         $display("[ERR] %0t seen %h want %h", $time, seen, want);
      end
   endtask
   // One APB transfer; read data lands in r
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge CLK);
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      @(posedge CLK);
      while (PREADY !== 1'b1)
         @(posedge CLK);
      r = PRDATA;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask
   // Issue a link command, then poll until it is no longer busy
   task automatic op(input logic rd, input logic [7:0] sel,
      input logic [7:0] v, input logic [7:0] ph);
      apb(1'b1, amb_pkg::AMB_REG_CMD, {7'h0, rd, ph, v, sel});
      apb(1'b0, amb_pkg::AMB_REG_RESULT, 32'h0);
      while (r[amb_pkg::AMB_RES_BUSY_BIT] !== 1'b0)
         apb(1'b0, amb_pkg::AMB_REG_RESULT, 32'h0);
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Hang guard, far above the roughly 300 cycles needed
   always @(posedge CLK)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         num_errors++;
         give_verdict();
      end
   end
   initial
   begin
      repeat (2) @(posedge CLK);
      RSTN <= 1'b1;
      repeat (4) @(posedge CLK);
      exp_m = amb_pkg::AMB_NVM_BACKED;
      check(MASKS, exp_m);
      apb(1'b1, amb_pkg::AMB_REG_INT_ENABLE, 32'h7);
      for (int k = 0; k < 12; k++)
      begin
         c = k % 4;
         seed = lfsr(seed);
         m = (k < 4) ? 8'hff : seed[7:0];
         op(1'b0, amb_pkg::AMB_SEL_IOUT + 8'(c), m, amb_pkg::AMB_PHASE_ALL);
         exp_m[c*8 +: 8] = m & amb_pkg::AMB_WRITABLE[c*8 +: 8];
         check(MASKS, exp_m);
         op(1'b1, amb_pkg::AMB_SEL_IOUT + 8'(c), 8'h00, amb_pkg::AMB_PHASE_ALL);
         check(32'(r[15:8]), 32'(exp_m[c*8 +: 8]));
         STATUS <= {seed, lfsr(seed)};
         repeat (3) @(posedge CLK);
         check(32'(ALERT), 32'(|(STATUS & ~exp_m)));
      end
      $display("test mask write and read done");
      op(1'b1, amb_pkg::AMB_SEL_OTHER, 8'h00, amb_pkg::AMB_PHASE_ALL);
      check(32'(r[15:8]), 32'(amb_pkg::AMB_OTHER_MASK));
      op(1'b0, amb_pkg::AMB_SEL_TEMP, 8'hff, 8'h00);
      check(32'(r[amb_pkg::AMB_RES_ERROR_BIT]), 32'h1);
      check(MASKS, exp_m);
      $display("test phase and other mask done");
      STATUS <= 32'h0;
      check(32'(IRQ), 32'h1);
      apb(1'b1, amb_pkg::AMB_REG_INT_CLEAR, 32'h7);
      apb(1'b0, amb_pkg::AMB_REG_INT_STATUS, 32'h0);
      check(r, 32'h0);
      apb(1'b1, amb_pkg::AMB_REG_INT_ENABLE, 32'h0);
      op(1'b1, amb_pkg::AMB_SEL_CML, 8'h00, amb_pkg::AMB_PHASE_ALL);
      apb(1'b0, amb_pkg::AMB_REG_INT_STATUS, 32'h0);
      check(32'(r[amb_pkg::AMB_INT_DONE_BIT]), 32'h1);
      check(32'(IRQ), 32'h0);
      $display("test interrupt done");
      give_verdict();
   end
endmodule
`default_nettype wire
